// [design/tos_pkg.sv]
// Shared constants and configuration carriers of the trigger output sequencer.
// Assumes a single 250 MHz system clock; every time field is in milliseconds.
package tos_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 250000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
    localparam int EMIT_HZ = 5000;
    localparam int EMIT_HALF = (CLK_KHZ * 1000) / (2 * EMIT_HZ);

    // ----------------------------------------------------------------
    // Sizes and reset values
    // ----------------------------------------------------------------
    localparam int N_BEAMS = 3;
    localparam int N_OUTS = 4;
    localparam int N_SWITCHES = 8;
    localparam int N_STEPS = 4;
    localparam int MS_W = 16;
    localparam logic [MS_W-1:0] MS_RESET = 16'h0000;
    localparam logic [7:0] REP_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_ACT = 3'h1;
    localparam logic [2:0] SRC_BEAM1 = 3'h2;
    localparam logic [2:0] SRC_BEAM2 = 3'h3;
    localparam logic [2:0] SRC_BEAM3 = 3'h4;
    localparam logic DRV_SINGLE = 1'b0;
    localparam logic DRV_CONT = 1'b1;
    localparam logic [1:0] STEP_OFF = 2'h0;
    localparam logic [1:0] STEP_MANUAL = 2'h1;
    localparam logic [1:0] STEP_FOLLOW = 2'h2;
    localparam logic [2:0] NEXT_END = 3'h0;
    localparam logic [2:0] STEP_ONE = 3'h1;
    localparam logic [2:0] STEP_TWO = 3'h2;
    localparam logic [2:0] STEP_THREE = 3'h3;
    localparam logic [2:0] STEP_FOUR = 3'h4;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] src;
        logic drive;
        logic [MS_W-1:0] lag;
        logic [MS_W-1:0] rel_time;
        logic [MS_W-1:0] period;
        logic [MS_W-1:0] interval;
        logic [7:0] reps;
        logic [16:0] win_start;
        logic [16:0] win_end;
    } tos_out_cfg_t;

    typedef struct packed {
        logic [1:0] trig;
        logic [MS_W-1:0] delay;
        logic [MS_W-1:0] on_time;
        logic [MS_W-1:0] duration;
        logic [7:0] reps;
        logic [N_SWITCHES-1:0] sw;
        logic [2:0] next;
    } tos_step_cfg_t;

endpackage

// [design/tos_chan.sv]
// One timed trigger output: lag, release pulses, interval and drive mode.
// Assumes a one-cycle millisecond tick and trigger events on the same clock.
`timescale 1ns/1ns
module tos_chan (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Timing and trigger inputs.
    input wire logic tick,
    input wire logic clr,
    input wire tos_pkg::tos_out_cfg_t cfg,
    input wire logic evt,
    input wire logic level,
    input wire logic win_ok,
    // Output drive.
    output logic out_on
);

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_LAG = 5'h02,
        S_ON = 5'h04,
        S_GAP = 5'h08,
        S_HOLD = 5'h10
    } tos_ch_state_t;

    tos_ch_state_t state;
    tos_ch_state_t next_state;
    logic [tos_pkg::MS_W-1:0] ph;
    logic [tos_pkg::MS_W-1:0] iv;
    logic [7:0] reps_left;

    // Trigger acceptance, interval completion and continuous restart.
    wire src_off = (cfg.src == tos_pkg::SRC_NONE);                       // R9
    wire acc = (state == S_IDLE) && evt && win_ok && !src_off;           // R3
    wire iv_done = (iv >= cfg.interval);                                 // R5
    wire restart = (cfg.drive == tos_pkg::DRV_CONT) && level && !src_off; // R8
    wire start = acc || ((state == S_HOLD) && iv_done && restart);
    wire first = (cfg.lag == tos_pkg::MS_RESET) ? 1'b1 : 1'b0;

    // Next state of the output cycle.
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (acc) begin
                    next_state = first ? S_ON : S_LAG;                   // R4
                end
            end
            S_LAG: begin
                if (ph >= cfg.lag) begin
                    next_state = S_ON;                                   // R6
                end
            end
            S_ON: begin
                if (ph >= cfg.rel_time) begin
                    next_state = (reps_left != 8'h00) ? S_GAP : S_HOLD;  // R19
                end
            end
            S_GAP: begin
                if (ph >= cfg.period) begin
                    next_state = S_ON;                                   // R6
                end
            end
            S_HOLD: begin
                if (iv_done) begin
                    next_state = restart ? (first ? S_ON : S_LAG) : S_IDLE; // R7
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (clr || src_off) begin
            next_state = S_IDLE;
        end
    end

    // State, phase counter, interval counter and remaining releases.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            ph <= tos_pkg::MS_RESET;
            iv <= tos_pkg::MS_RESET;
            reps_left <= tos_pkg::REP_RESET;
            out_on <= 1'b0;
        end else begin
            state <= next_state;
            out_on <= (next_state == S_ON);
            if ((next_state != state && next_state != S_GAP) || start) begin
                ph <= tos_pkg::MS_RESET;                                 // R6
            end else if (tick) begin
                ph <= ph + 16'h0001;
            end
            if (start) begin
                iv <= tos_pkg::MS_RESET;
            end else if (tick && iv != 16'hffff) begin
                iv <= iv + 16'h0001;
            end
            if (start) begin
                reps_left <= cfg.reps;                                   // R20
            end else if (state == S_ON && next_state == S_GAP) begin
                reps_left <= reps_left - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    src_none_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // R9
        src_off |=> !out_on && state == S_IDLE)
        else $error("Output with no trigger source is active.");
    busy_no_restart_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
        (state == S_LAG || state == S_ON || state == S_GAP) && !clr && !src_off
        |=> iv >= $past(iv))
        else $error("Interval restarted while the output was busy.");
    zero_lag_on_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4
        acc && first && !clr |=> out_on && state == S_ON)
        else $error("Zero lag output did not switch on at acceptance.");
    wait_interval_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        state == S_HOLD && !iv_done && !clr && !src_off |=> state == S_HOLD)
        else $error("Output left the interval before it elapsed.");
    lag_dark_a: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        state == S_LAG |-> !out_on)
        else $error("Output on during lag time.");
    ready_at_end_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
        state == S_HOLD && iv_done && !restart && !clr |=> state == S_IDLE)
        else $error("Output not ready once the interval elapsed.");
    cont_restart_a: assert property (@(posedge mclk) disable iff (sys_rst) // R8
        state == S_HOLD && iv_done && restart && !clr
        |=> (state == S_ON || state == S_LAG) && iv == tos_pkg::MS_RESET)
        else $error("Continuous mode did not start a new cycle.");
    extra_release_a: assert property (@(posedge mclk) disable iff (sys_rst) // R19
        state == S_ON && next_state == S_GAP |=> reps_left == $past(reps_left) - 8'h01)
        else $error("Release added beyond the repetition count.");

endmodule

// [design/tos_seq.sv]
// Top of the trigger output sequencer: input synchronisers, millisecond tick,
// emitter modulation, four timed outputs and four chained experimental steps.
// Assumes beam, action-mode and key inputs are asynchronous pins, active high,
// and that configuration ports are held steady by the surrounding controller.
`timescale 1ns/1ns

// Contract
// [R1] Events for a source no output or step selects change nothing.
// [R2] Action-mode and beam events from one interruption appear in the same cycle.
// [R3] Triggers arriving before the interval elapsed are dropped, never queued.
// [R4] With zero lag the output switches on at acceptance for the release time.
// [R5] Readiness returns no earlier than trigger time plus interval.
// [R6] Lag first, then release pulses spaced by period, then the interval.
// [R7] Equal release time, period and interval give readiness at pulse end.
// [R8] Continuous mode restarts full cycles while the selected input stays interrupted.
// [R9] Source none keeps the output off and deaf to all events.
// [R10] Manual step starts on the key, waits its delay, closes its switches.
// [R11] Step duration timed from step start, then hands to next step or ends.
// [R12] A chain with zero repetitions runs exactly once per start.
// [R13] Software should make step duration exceed delay plus ON time.
// [R14] All manual chains start together on one key press and run concurrently.
// [R15] Starting needs no return to working level after a value change.
// [R16] Steps work only while experimental mode is enabled.
// [R17] Three beam inputs, four outputs and eight switches.
// [R18] Emitter pulses at fixed rate; beam response stays within its time.
// [R19] Each repetition adds one release after the first.
// [R20] Single mode with zero repetitions runs once per accepted trigger.
// [R21] Equal window start and end accept triggers at any time of day.
// [R22] All times count a common millisecond tick with a synchronous clear.
// [R23] A follow step starts only on handover from its preceding step.
module tos_seq #(
    parameter int TICK_CYCLES = tos_pkg::TICK_CYCLES,
    parameter int EMIT_HALF = tos_pkg::EMIT_HALF
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Front-end pins.
    input wire logic [tos_pkg::N_BEAMS-1:0] beam_cut,
    input wire logic act_hit,
    input wire logic start_key,
    // Control and configuration.
    input wire logic timer_clr,
    input wire logic exp_mode,
    input wire logic [16:0] tod,
    input wire tos_pkg::tos_out_cfg_t [tos_pkg::N_OUTS-1:0] out_cfg,
    input wire tos_pkg::tos_step_cfg_t [tos_pkg::N_STEPS-1:0] step_cfg,
    // Drives.
    output logic [tos_pkg::N_OUTS-1:0] out_on,
    output logic [tos_pkg::N_SWITCHES-1:0] switch_on,
    output logic emitter
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int EW = $clog2(EMIT_HALF + 1);
    localparam int NS = tos_pkg::N_STEPS;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Picks the action-mode or beam bit that a trigger source names.
    function automatic logic src_pick(input logic [2:0] src, input logic [3:0] v);
        logic r;
        r = 1'b0;
        case (src)
            tos_pkg::SRC_ACT: r = v[0];
            tos_pkg::SRC_BEAM1: r = v[1];
            tos_pkg::SRC_BEAM2: r = v[2];
            tos_pkg::SRC_BEAM3: r = v[3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // True when the time of day lies inside a window, or the window is empty.
    function automatic logic in_window(input logic [16:0] ws, input logic [16:0] we,
                                       input logic [16:0] t);
        logic r;
        r = 1'b1;
        if (ws < we) begin
            r = (t >= ws) && (t < we);
        end else if (ws > we) begin
            r = (t >= ws) || (t < we);
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] sy3;
    logic [4:0] lvl;
    logic [4:0] lvl_d;

    // A bit is taken only once the second and third stages agree.
    wire [4:0] agree = ~(sy2 ^ sy3);
    wire [4:0] next_lvl = (sy3 & agree) | (lvl & ~agree);
    // All front-end events come from one edge detector in the same cycle.
    wire [4:0] rise = lvl & ~lvl_d;                                      // R2
    wire key_evt = rise[4];

    // Three-stage capture of action, beams and key, then edge detection.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sy1 <= 5'h00;
            sy2 <= 5'h00;
            sy3 <= 5'h00;
            lvl <= 5'h00;
            lvl_d <= 5'h00;
        end else begin
            sy1 <= {start_key, beam_cut, act_hit};                       // R17
            sy2 <= sy1;
            sy3 <= sy2;
            lvl <= next_lvl;                                             // R18
            lvl_d <= lvl;
        end
    end

    // ----------------------------------------------------------------
    // Millisecond tick and emitter modulation
    // ----------------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [EW-1:0] emit_cnt;

    // Divider wrap points.
    wire tick_wrap = (tick_cnt == TW'(TICK_CYCLES - 1));
    wire emit_wrap = (emit_cnt == EW'(EMIT_HALF - 1));

    // Common time base for every output and step.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (timer_clr) begin
            tick_cnt <= '0;                                              // R22
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + TW'(1);
            tick <= tick_wrap;                                           // R22
        end
    end

    // Emitter square wave at the fixed modulation rate.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            emit_cnt <= '0;
            emitter <= 1'b0;
        end else begin
            emit_cnt <= emit_wrap ? '0 : emit_cnt + EW'(1);
            if (emit_wrap) begin
                emitter <= ~emitter;                                     // R18
            end
        end
    end

    // ----------------------------------------------------------------
    // Timed outputs
    // ----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < tos_pkg::N_OUTS; k = k + 1) begin : g_out
            // Each output sees only the event of its own source.
            wire evt = src_pick(out_cfg[k].src, rise[3:0]);              // R1
            wire lv = src_pick(out_cfg[k].src, lvl[3:0]);
            wire wok = in_window(out_cfg[k].win_start, out_cfg[k].win_end, tod); // R21
            tos_chan u_chan (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .tick(tick),
                .clr(timer_clr),
                .cfg(out_cfg[k]),
                .evt(evt),
                .level(lv),
                .win_ok(wok),
                .out_on(out_on[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Experimental step chains
    // ----------------------------------------------------------------
    // Step chain state.
    logic [NS-1:0] run;
    logic [tos_pkg::MS_W-1:0] sc [NS];
    logic [1:0] head [NS];
    logic [7:0] rep_left [NS];
    logic [NS-1:0] hand;
    logic [NS-1:0] again;
    logic [1:0] hand_head [NS];
    logic [NS-1:0] go;
    logic [NS-1:0] manual;
    logic [NS-1:0] step_end;
    logic [NS-1:0] closed;

    // Step end, switch closure and manual start per step.
    genvar j;
    generate
        for (j = 0; j < NS; j = j + 1) begin : g_step
            wire [16:0] on_end = {1'b0, step_cfg[j].delay} + {1'b0, step_cfg[j].on_time};
            assign step_end[j] = run[j] && (sc[j] >= step_cfg[j].duration); // R11
            assign closed[j] = run[j] && (sc[j] >= step_cfg[j].delay)
                && ({1'b0, sc[j]} < on_end);                             // R10
            // Every idle manual step answers the same key event; a running one ignores it.
            assign manual[j] = key_evt && (step_cfg[j].trig == tos_pkg::STEP_MANUAL)
                && !run[j];                                              // R14
            assign go[j] = exp_mode && (manual[j] || hand[j] || again[j]); // R16
        end
    endgenerate

    // Handover to a named next step, and chain repetition from the head.
    always_comb begin
        hand = '0;
        again = '0;
        for (int n = 0; n < NS; n = n + 1) begin
            hand_head[n] = 2'(n);
        end
        for (int i = 0; i < NS; i = i + 1) begin
            if (step_end[i] && step_cfg[i].next != tos_pkg::NEXT_END) begin
                for (int n = 0; n < NS; n = n + 1) begin
                    if (step_cfg[i].next == 3'(n + 1)) begin
                        hand[n] = 1'b1;                                  // R23
                        hand_head[n] = head[i];
                    end
                end
            end else if (step_end[i] && rep_left[head[i]] != 8'h00) begin
                again[head[i]] = 1'b1;                                   // R12
            end
        end
    end

    // Step run flags, step clocks, chain heads and repetition counts.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            run <= '0;
            for (int n = 0; n < NS; n = n + 1) begin
                sc[n] <= tos_pkg::MS_RESET;
                head[n] <= 2'(n);
                rep_left[n] <= tos_pkg::REP_RESET;
            end
        end else begin
            for (int n = 0; n < NS; n = n + 1) begin
                if (!exp_mode || timer_clr) begin
                    run[n] <= 1'b0;                                      // R16
                end else if (go[n]) begin
                    run[n] <= 1'b1;                                      // R15
                end else if (step_end[n]) begin
                    run[n] <= 1'b0;                                      // R11
                end
                if (go[n]) begin
                    sc[n] <= tos_pkg::MS_RESET;
                end else if (tick && run[n]) begin
                    sc[n] <= sc[n] + 16'h0001;                           // R22
                end
                if (manual[n]) begin
                    head[n] <= 2'(n);
                    rep_left[n] <= step_cfg[n].reps;                     // R12
                end else if (hand[n]) begin
                    head[n] <= hand_head[n];
                end else if (again[n]) begin
                    head[n] <= 2'(n);
                    rep_left[n] <= rep_left[n] - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Switch drive
    // ----------------------------------------------------------------
    logic [tos_pkg::N_SWITCHES-1:0] next_switch;

    // Each output closes its own pair; closed steps add their switch masks.
    always_comb begin
        next_switch = '0;
        for (int n = 0; n < tos_pkg::N_OUTS; n = n + 1) begin
            next_switch[2*n] = out_on[n];
            next_switch[2*n+1] = out_on[n];
        end
        for (int n = 0; n < NS; n = n + 1) begin
            if (closed[n]) begin
                next_switch = next_switch | step_cfg[n].sw;              // R10
            end
        end
    end

    // Registered switch outputs.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            switch_on <= '0;
        end else begin
            switch_on <= next_switch;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    generate
        for (j = 0; j < NS; j = j + 1) begin : g_chk
            // Per-step checks.
            step_switch_a: assert property (@(posedge mclk) disable iff (sys_rst) // R10
                closed[j] |=> (switch_on & step_cfg[j].sw) == step_cfg[j].sw)
                else $error("Step switch not closed during its ON time.");

            chain_end_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
                step_end[j] && !go[j] |=> !run[j])
                else $error("Step kept running after its duration.");

            once_per_start_a: assert property (@(posedge mclk) disable iff (sys_rst) // R12
                go[j] && manual[j] && !timer_clr
                |=> rep_left[j] == $past(step_cfg[j].reps) && run[j])
                else $error("Manual start did not load the chain repetitions.");

            exp_gate_a: assert property (@(posedge mclk) disable iff (sys_rst) // R16
                !exp_mode |=> !run[j])
                else $error("Step running with experimental mode off.");

            follow_start_a: assert property (@(posedge mclk) disable iff (sys_rst) // R23
                hand[j] && exp_mode && !timer_clr |=> run[j] && sc[j] == tos_pkg::MS_RESET)
                else $error("Next step did not start on handover.");
        end
    endgenerate

    // Time base checks.
    emit_steady_a: assert property (@(posedge mclk) disable iff (sys_rst) // R18
        !emit_wrap |=> $stable(emitter))
        else $error("Emitter toggled between half periods.");

    tick_single_a: assert property (@(posedge mclk) disable iff (sys_rst) // R22
        tick |=> !tick [*3])
        else $error("Millisecond tick longer than one cycle.");

    clr_stops_a: assert property (@(posedge mclk) disable iff (sys_rst) // R22
        timer_clr |=> run == '0 && !tick)
        else $error("Clear left a step running or a tick pending.");

endmodule

// [test/tos_contacts.sv]
// Far-side contact model: camera, flash and valve contacts on the eight switches.
// Assumes switch levels from the sequencer on the same system clock.
`timescale 1ns/1ns
module tos_contacts (
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Switch levels and closure count.
    input wire logic [7:0] switch_on,
    output int closures
);
    logic [7:0] was;

    // Each open-to-closed change is one contact closure.
    always @(posedge mclk) begin
        if (sys_rst) begin
            closures <= 0;
            was <= 8'h00;
        end else begin
            closures <= closures + $countones(switch_on & ~was);
            was <= switch_on;
        end
    end
endmodule

// [test/tb_trigger_output_sequencer.sv]
// Bench for the sequencer: drives pins and configuration, queues pulse notes.
// Assumes the contact model beside it and a ten-cycle millisecond tick.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_trigger_output_sequencer;
    logic mclk = 1'b0, sys_rst = 1'b1, start_key = 1'b0, act_hit = 1'b0, exp_mode = 1'b1;
    logic [2:0] beam_cut = 3'h0;
    logic timer_clr = 1'b0, emitter, emit_d;
    logic [16:0] tod = 17'h00000;
    tos_pkg::tos_out_cfg_t [3:0] out_cfg = '0;
    tos_pkg::tos_step_cfg_t [3:0] step_cfg = '0;
    logic [3:0] out_on;
    logic [7:0] switch_on;
    logic [11:0] q[$], was, rise, want;
    int bad_count = 0, n_tests = 0, n_close = 0, closures, cyc = 0, seed = 62131, emit_gap = 0;

    tos_seq #(.TICK_CYCLES(10), .EMIT_HALF(5)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .beam_cut(beam_cut), .act_hit(act_hit), .start_key(start_key), .timer_clr(timer_clr),
        .exp_mode(exp_mode), .tod(tod), .out_cfg(out_cfg), .step_cfg(step_cfg),
        .out_on(out_on), .switch_on(switch_on), .emitter(emitter));
    tos_contacts i_far (.mclk(mclk), .sys_rst(sys_rst), .switch_on(switch_on),
        .closures(closures));

    // Free-running system clock.
    initial forever #2 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    // Every new rise of an output or switch must match the oldest note.
    assign rise = {switch_on, out_on} & ~was;
    always @(posedge mclk) begin
        was <= sys_rst ? 12'h000 : {switch_on, out_on};
        cyc <= cyc + 1;
        emit_d <= emitter;
        emit_gap <= (emitter !== emit_d) ? 1 : emit_gap + 1;
        if (cyc > 20 && emitter !== emit_d) `CHK(emit_gap, 5)
        if (!sys_rst && rise != 12'h000) begin
            want = (q.size() > 0) ? q.pop_front() : 12'h000;
            `CHK(rise, want)
        end
        if (cyc == 4000) begin
            bad_count++;
            end_of_test();
        end
    end

    // Closing report and verdict.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    // Notes one output rise mask and the switch rise that follows it.
    task automatic note(logic [3:0] m, logic [7:0] s);
        if (m != 4'h0) q.push_back({8'h00, m});
        q.push_back({s, 4'h0});
        n_close += $countones(s);
    endtask

    // Raises pins {key, act, beams} for n cycles, then idles w cycles.
    task automatic hit(logic [4:0] m, int n, int w);
        {start_key, act_hit, beam_cut} <= m;
        repeat (n) @(posedge mclk);
        {start_key, act_hit, beam_cut} <= 5'h00;
        repeat (w) @(posedge mclk);
    endtask

    task automatic set_out(int k, logic [2:0] s, logic d, logic [15:0] lg, rl, pr, iv,
                           logic [7:0] rp);
        out_cfg[k] <= '{s, d, lg, rl, pr, iv, rp, tod, tod};
    endtask

    task automatic set_step(int k, logic [1:0] t, logic [15:0] dl, on, du, logic [7:0] sw,
                            logic [2:0] nx);
        step_cfg[k] <= '{t, dl, on, du, 8'h00, sw, nx};
    endtask

    // Output timing, then continuous mode, then step chains.
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        tod <= 17'($random(seed));
        @(posedge mclk);
        set_out(0, tos_pkg::SRC_ACT, 1'b0, 16'h0, 16'h2, 16'h2, 16'h14, 8'h0);
        set_out(1, tos_pkg::SRC_ACT, 1'b0, 16'h4, 16'h1, 16'h8, 16'h10, 8'h1);
        set_out(2, tos_pkg::SRC_BEAM2, 1'b0, 16'h0, 16'h1, 16'h1, 16'h1, 8'h0);
        hit(5'h01, 5, 100);
        note(4'h5, 8'h33); note(4'h2, 8'h0c); note(4'h4, 8'h30); note(4'h2, 8'h0c);
        hit(5'h0a, 5, 80);
        hit(5'h0a, 5, 300);
        note(4'h1, 8'h03); note(4'h2, 8'h0c); note(4'h2, 8'h0c);
        hit(5'h08, 5, 300);
        for (int k = 0; k < 3; k++) set_out(k, tos_pkg::SRC_NONE, 1'b0, 0, 0, 0, 0, 8'h0);
        set_out(3, tos_pkg::SRC_BEAM3, tos_pkg::DRV_CONT, 16'h0, 16'h1, 16'h1, 16'h5, 8'h0);
        note(4'h8, 8'hc0); note(4'h8, 8'hc0);
        hit(5'h04, 70, 200);
        set_out(3, tos_pkg::SRC_NONE, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h0);
        set_step(0, tos_pkg::STEP_MANUAL, 16'h7, 16'h2, 16'ha, 8'h01, tos_pkg::NEXT_END);
        set_step(1, tos_pkg::STEP_MANUAL, 16'h0, 16'h2, 16'h4, 8'h02, tos_pkg::STEP_THREE);
        set_step(2, tos_pkg::STEP_FOLLOW, 16'h0, 16'h1, 16'h3, 8'h02, tos_pkg::NEXT_END);
        repeat (2) begin
            note(4'h0, 8'h02); note(4'h0, 8'h02); note(4'h0, 8'h01);
            hit(5'h10, 5, 200);
        end
        note(4'h0, 8'h02);
        hit(5'h10, 12, 0);
        timer_clr <= 1'b1;
        @(posedge mclk);
        timer_clr <= 1'b0;
        repeat (100) @(posedge mclk);
        exp_mode <= 1'b0;
        hit(5'h10, 5, 200);
        `CHK(q.size(), 0)
        `CHK(closures, n_close)
        end_of_test();
    end
endmodule
